// File: sac_device.sv
// What this block does
// - Mode pin high selects serial, low parallel.
// - Six-bit shift register, top bit first.
// - Each bit carries a binary attenuation weight.
// - Attenuation is sum of set weights.
// - Serial strobe rising copies shift register to active.
// - Latched serial: controller holds strobe low while shifting.
// - Strobe low: shifting never touches active register.
// - Latched loads: controller drops strobe before next word.
// - Controller waits 100 ns after mode rise.
// - Data sampled on rising serial clock edges.
// - Strobe rises after last bit, falls before clock.
// - Strobe held high: active follows every shift.
// - Controller prefers latched serial loading.
// - Serial power-up gives all ones.
// - Parallel with strobe high follows pins continuously.
// - Direct parallel start takes pin levels.
// - Parallel with strobe low holds attenuation.
// - Parallel strobe rising adopts the pin value.
// - Latched parallel starts at maximum attenuation.
module sac_device
    import sac_pkg::*;
#(
    parameter int WORD_W = SAC_WORD_W
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Control pins from the controller.
    sac_if.dev pins,
    // Attenuation state.
    output logic [WORD_W-1:0] atten_code_q,
    output logic [WORD_W-1:0] atten_halfdb_q,
    output logic serial_mode_q,
    output logic update_q
);

    // Operating modes as decoded from the mode pin and the strobe level.
    typedef enum logic [1:0] {
        MODE_CONV_SER = 2'b00,
        MODE_DIR_SER = 2'b01,
        MODE_DIR_PAR = 2'b10,
        MODE_LAT_PAR = 2'b11
    } sac_mode_t;

    // Sum of the weights of the set bits, in units of 0.5 dB.
    function automatic logic [WORD_W-1:0] sac_weight_sum(input logic [WORD_W-1:0] code);
        logic [WORD_W-1:0] sum;
        sum = '0;
        for (int i = 0; i < WORD_W; i++) begin
            if (code[i]) begin
                sum = sum + (WORD_W'(1) << i);
            end
        end
        return sum;
    endfunction

    logic [9:0] raw_pins;
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic clk_prev_q;
    logic strobe_prev_q;
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] shift_d;
    logic [WORD_W-1:0] active_q;
    logic [WORD_W-1:0] active_d;
    logic load;
    sac_mode_t mode;

    assign raw_pins = {pins.mode_sel, pins.ser_clk, pins.ser_data, pins.latch_strobe, pins.par_bits};

    // Every pin is asynchronous to sys_clk; the first stage feeds only the second.
    // Clock and data go through equal depth so their alignment is kept.
    genvar g;
    generate
        for (g = 0; g < 10; g++) begin : gen_sync
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    sync1_q[g] <= SAC_SYNC_RESET[g];
                    sync2_q[g] <= SAC_SYNC_RESET[g];
                end else begin
                    sync1_q[g] <= raw_pins[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    wire mode_serial = sync2_q[SAC_SYNC_MODE];
    wire clk_s = sync2_q[SAC_SYNC_CLK];
    wire data_s = sync2_q[SAC_SYNC_DATA];
    wire strobe_s = sync2_q[SAC_SYNC_STROBE];
    wire [WORD_W-1:0] par_s = sync2_q[WORD_W-1:0];

    // Edge detection works on synchronised levels only.
    wire clk_rise = clk_s & ~clk_prev_q;
    wire strobe_rise = strobe_s & ~strobe_prev_q;

    // Mode decode: strobe level picks direct against latched behaviour.
    always_comb begin
        if (mode_serial) begin
            mode = strobe_s ? MODE_DIR_SER : MODE_CONV_SER;
        end else begin
            mode = strobe_s ? MODE_DIR_PAR : MODE_LAT_PAR;
        end
    end

    // Serial clock edges only shift while the mode pin says serial.
    wire shift_en = mode_serial & clk_rise;

    always_comb begin
        shift_d = shift_q;
        if (shift_en) begin
            shift_d = {shift_q[WORD_W-2:0], data_s};
        end
    end

    // Next active value by mode.
    always_comb begin
        active_d = active_q;
        load = 1'b0;
        case (mode)
            MODE_CONV_SER: begin
                // Shifting continues here but the active value stays put.
                active_d = active_q;
            end
            MODE_DIR_SER: begin
                if (strobe_rise) begin
                    active_d = shift_q;
                    load = 1'b1;
                end else if (shift_en) begin
                    // Intermediate words appear here; swings of up to 16 dB are expected.
                    active_d = shift_d;
                    load = 1'b1;
                end
            end
            MODE_DIR_PAR: begin
                // Pins are followed every cycle, including straight after reset.
                active_d = par_s;
                load = (par_s != active_q) | strobe_rise;
            end
            MODE_LAT_PAR: begin
                // Pins may move freely; serial activity is also ignored here.
                active_d = active_q;
            end
            default: begin
                active_d = active_q;
            end
        endcase
    end

    // Edge memories reset to the synchroniser levels, so no false edge follows reset.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_prev_q <= SAC_SYNC_RESET[SAC_SYNC_CLK];
        end else begin
            clk_prev_q <= clk_s;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strobe_prev_q <= SAC_SYNC_RESET[SAC_SYNC_STROBE];
        end else begin
            strobe_prev_q <= strobe_s;
        end
    end

    // Reset to all ones so that holding the strobe high at start-up in serial
    // mode keeps every bit not yet shifted in at its full weight until the word arrives.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_q <= SAC_RESET_CODE;
        end else begin
            shift_q <= shift_d;
        end
    end

    // Power-up in serial or latched parallel gives maximum attenuation.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            active_q <= SAC_RESET_CODE;
        end else begin
            active_q <= active_d;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            atten_code_q <= SAC_RESET_CODE;
            atten_halfdb_q <= SAC_RESET_CODE;
        end else begin
            atten_code_q <= active_d;
            atten_halfdb_q <= sac_weight_sum(active_d);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serial_mode_q <= SAC_SYNC_RESET[SAC_SYNC_MODE];
            update_q <= 1'b0;
        end else begin
            serial_mode_q <= mode_serial;
            update_q <= load;
        end
    end

endmodule

// File: sac_pkg.sv
package sac_pkg;

    // Control word layout.
    localparam int SAC_WORD_W = 6;
    localparam int WEIGHT_16DB_BIT = 5;
    localparam int WEIGHT_HALF_DB_BIT = 0;

    // Power-up value of the active register: all ones, 31.5 dB.
    localparam logic [5:0] SAC_RESET_CODE = 6'h3f;

    // Synchroniser reset levels, ordered mode, clock, data, strobe, parallel[5:0].
    // The pins idle high through pull-ups, so mode, strobe and parallel reset high.
    localparam logic [9:0] SAC_SYNC_RESET = 10'h27f;
    localparam int SAC_SYNC_MODE = 9;
    localparam int SAC_SYNC_CLK = 8;
    localparam int SAC_SYNC_DATA = 7;
    localparam int SAC_SYNC_STROBE = 6;

    // Timing.
    localparam int SAC_SYS_CLK_NS = 40;
    localparam int SAC_MODE_SETUP_NS = 100;
    localparam int SAC_MODE_SETUP_CYC = (SAC_MODE_SETUP_NS + SAC_SYS_CLK_NS - 1) / SAC_SYS_CLK_NS;
    localparam int SAC_HALF_PERIOD_NS = 160;
    localparam int SAC_HALF_PERIOD_CYC = (SAC_HALF_PERIOD_NS / SAC_SYS_CLK_NS < 1) ? 1 :
                                         SAC_HALF_PERIOD_NS / SAC_SYS_CLK_NS;

    // Loading methods, as seen by both ends.
    typedef enum logic [1:0] {
        SAC_CONV_SERIAL = 2'b00,
        SAC_DIRECT_SERIAL = 2'b01,
        SAC_DIRECT_PARALLEL = 2'b10,
        SAC_LATCHED_PARALLEL = 2'b11
    } sac_method_t;

endpackage

// File: sac_if.sv
interface sac_if;
    logic mode_sel;
    logic ser_clk;
    logic ser_data;
    logic latch_strobe;
    logic [5:0] par_bits;

    modport dev (
        input mode_sel,
        input ser_clk,
        input ser_data,
        input latch_strobe,
        input par_bits
    );

    modport ctl (
        output mode_sel,
        output ser_clk,
        output ser_data,
        output latch_strobe,
        output par_bits
    );
endinterface

// File: sac_host.sv
module sac_host
    import sac_pkg::*;
#(
    parameter int WORD_W = SAC_WORD_W,
    parameter int HALF_CYC = SAC_HALF_PERIOD_CYC,
    parameter int SETUP_CYC = SAC_MODE_SETUP_CYC
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Command port.
    input wire logic start,
    input wire logic [1:0] method,
    input wire logic [WORD_W-1:0] word,
    output logic busy_q,
    output logic done_q,
    // Control pins toward the device.
    sac_if.ctl pins
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_CLK_LOW = 3'b010,
        ST_CLK_HIGH = 3'b011,
        ST_STROBE_HI = 3'b100,
        ST_FINISH = 3'b101
    } sac_hstate_t;

    sac_hstate_t state_q;
    logic [1:0] method_q;
    logic [WORD_W-1:0] word_q;
    logic [2:0] bit_q;
    logic [7:0] div_q;
    logic [7:0] wait_q;
    logic mode_q;
    logic clk_q;
    logic data_q;
    logic strobe_q;
    logic [WORD_W-1:0] par_q;

    // Free-running divider: one enable pulse per half serial clock period.
    wire tick = (div_q == 8'(HALF_CYC - 1));
    wire want_serial = ~method[1];
    wire is_serial = ~method_q[1];
    wire is_direct = method_q[0] ^ method_q[1];
    wire conv_serial = (method_q == SAC_CONV_SERIAL);

    assign pins.mode_sel = mode_q;
    assign pins.ser_clk = clk_q;
    assign pins.ser_data = data_q;
    assign pins.latch_strobe = strobe_q;
    assign pins.par_bits = par_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q <= 8'h00;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            method_q <= SAC_CONV_SERIAL;
            word_q <= '0;
            bit_q <= 3'h0;
            wait_q <= 8'h00;
            mode_q <= 1'b1;
            clk_q <= 1'b0;
            data_q <= 1'b0;
            strobe_q <= 1'b0;
            par_q <= SAC_RESET_CODE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        method_q <= method;
                        word_q <= word;
                        busy_q <= 1'b1;
                        mode_q <= want_serial;
                        // A direct serial load keeps the strobe high throughout.
                        strobe_q <= (method == SAC_DIRECT_SERIAL);
                        if (!want_serial) begin
                            par_q <= word;
                        end
                        wait_q <= (want_serial & ~mode_q) ? 8'(SETUP_CYC) : 8'h00;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (wait_q != 8'h00) begin
                        wait_q <= wait_q - 8'h01;
                    end else if (tick) begin
                        if (is_serial) begin
                            data_q <= word_q[WORD_W-1];
                            bit_q <= 3'(WORD_W - 1);
                            state_q <= ST_CLK_LOW;
                        end else begin
                            strobe_q <= 1'b1;
                            state_q <= is_direct ? ST_FINISH : ST_STROBE_HI;
                        end
                    end
                end
                ST_CLK_LOW: begin
                    if (tick) begin
                        clk_q <= 1'b1;
                        state_q <= ST_CLK_HIGH;
                    end
                end
                ST_CLK_HIGH: begin
                    if (tick) begin
                        clk_q <= 1'b0;
                        if (bit_q == 3'h0) begin
                            // Strobe rises only once the last bit is in.
                            strobe_q <= conv_serial ? 1'b1 : strobe_q;
                            state_q <= conv_serial ? ST_STROBE_HI : ST_FINISH;
                        end else begin
                            // Data moves on the falling edge, half a period from either rise.
                            data_q <= word_q[bit_q - 3'h1];
                            bit_q <= bit_q - 3'h1;
                            state_q <= ST_CLK_LOW;
                        end
                    end
                end
                ST_STROBE_HI: begin
                    if (tick) begin
                        strobe_q <= 1'b0;
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: sac_link_checker.sv
module sac_link_checker
    import sac_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Link wires.
    input wire logic mode_sel,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic latch_strobe,
    input wire logic [5:0] par_bits,
    // Device state.
    input wire logic [5:0] atten_code_q,
    input wire logic [5:0] atten_halfdb_q,
    input wire logic serial_mode_q,
    input wire logic update_q
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    reset_code_a: assert property ($fell(rst) |-> atten_code_q == SAC_RESET_CODE && serial_mode_q)
        else $error("Code not at maximum after reset.");
    weight_sum_a: assert property (atten_halfdb_q == atten_code_q)
        else $error("Half dB sum differs from code.");
    update_mark_a: assert property ($changed(atten_code_q) |-> update_q)
        else $error("Code changed without update pulse.");
    // Six cycles cover the two synchroniser stages plus the load register.
    strobe_hold_a: assert property ((!latch_strobe) [*6] |-> $stable(atten_code_q))
        else $error("Code moved while strobe low.");
    par_follow_a: assert property ((!mode_sel && latch_strobe && $stable(par_bits)) [*6] |-> atten_code_q == par_bits)
        else $error("Code does not follow parallel pins.");
    strobe_order_a: assert property ($rose(latch_strobe) && mode_sel |-> !ser_clk)
        else $error("Strobe rose with serial clock high.");
    mode_setup_a: assert property ($rose(mode_sel) |-> !ser_clk [*3])
        else $error("Serial clock too soon after mode rise.");
    data_hold_a: assert property ($rose(ser_clk) |-> $stable(ser_data) ##1 $stable(ser_data))
        else $error("Serial data moved around clock rise.");
    mode_track_a: assert property ($stable(mode_sel) [*4] |-> serial_mode_q == mode_sel)
        else $error("Mode flag does not track mode pin.");

    cover property ($rose(latch_strobe) && mode_sel);
    cover property ((!mode_sel && latch_strobe) [*6]);
    cover property (update_q && serial_mode_q && latch_strobe);
endmodule

// File: step_attenuator_control_port_test.sv
module step_attenuator_control_port_test
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [1:0] method = 2'h0;
    logic [5:0] word = 6'h00;
    logic busy_q, done_q, serial_mode_q, update_q;
    logic [5:0] atten_code_q, atten_halfdb_q;
    logic [5:0] sr = 6'h3f;
    logic [5:0] ups[$];
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    integer seed = 34;

    sac_if i_sac_if ();
    sac_device i_sac_device (.sys_clk(sys_clk), .rst(rst), .pins(i_sac_if.dev), .atten_code_q(atten_code_q),
        .atten_halfdb_q(atten_halfdb_q), .serial_mode_q(serial_mode_q), .update_q(update_q));
    sac_host i_sac_host (.sys_clk(sys_clk), .rst(rst), .start(start), .method(method), .word(word),
        .busy_q(busy_q), .done_q(done_q), .pins(i_sac_if.ctl));
    sac_link_checker i_sac_link_checker (.sys_clk(sys_clk), .rst(rst), .mode_sel(i_sac_if.mode_sel),
        .ser_clk(i_sac_if.ser_clk), .ser_data(i_sac_if.ser_data), .latch_strobe(i_sac_if.latch_strobe),
        .par_bits(i_sac_if.par_bits), .atten_code_q(atten_code_q), .atten_halfdb_q(atten_halfdb_q),
        .serial_mode_q(serial_mode_q), .update_q(update_q));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // Sampled on the falling edge, when update and code from the same edge have both landed.
    always @(negedge sys_clk) begin
        if (update_q === 1'b1) begin
            ups.push_back(atten_code_q);
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Checks: %0d, mismatches: %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    function automatic int tenths(input logic [5:0] c);
        int w[6] = '{5, 10, 20, 40, 80, 160};
        tenths = 0;
        for (int b = 0; b < 6; b++) begin
            if (c[b]) tenths += w[b];
        end
    endfunction

    // A second start while busy must be dropped, so junk sends an inverted word mid-command.
    task automatic run(input logic [1:0] m, input logic [5:0] w, input bit junk);
        int k;
        logic [5:0] s;
        ups.delete();
        @(posedge sys_clk);
        #2;
        start = 1'b1;
        method = m;
        word = w;
        @(posedge sys_clk);
        #2;
        start = 1'b0;
        chk({5'h00, busy_q}, 6'h01);
        if (junk) begin
            repeat (10) @(posedge sys_clk);
            #2;
            start = 1'b1;
            word = ~w;
            @(posedge sys_clk);
            #2;
            start = 1'b0;
        end
        k = 0;
        while (done_q !== 1'b1 && k < 400) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k >= 400) begin
            $display("CHECK FAILED at %0t: done %h expected %h", $time, done_q, 1'b1);
            fail_count++;
        end
        // The device lags the pins by its synchronisers, so let it settle before looking.
        repeat (4) @(posedge sys_clk);
        #1;
        chk({5'h00, busy_q}, 6'h00);
        chk(atten_code_q, w);
        chk(atten_halfdb_q, 6'(tenths(w) / 5));
        chk({5'h00, serial_mode_q}, {5'h00, m < 2'h2});
        if (m == SAC_CONV_SERIAL) begin
            chk(6'(ups.size()), 6'h01);
        end
        if (m == SAC_DIRECT_SERIAL) begin
            for (int i = 1; i <= 6; i++) begin
                s = (sr << i) | (w >> (6 - i));
                chk(ups[ups.size() - 7 + i], s);
            end
        end
        if (m == SAC_DIRECT_PARALLEL) begin
            chk(ups[$], w);
        end
        if (m == SAC_LATCHED_PARALLEL) begin
            chk(6'(ups.size()), 6'h01);
        end
        if (m < 2'h2) sr = w;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        #2;
        rst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(atten_code_q, SAC_RESET_CODE);
        run(SAC_CONV_SERIAL, 6'h00, 1'b0);
        run(SAC_LATCHED_PARALLEL, 6'h3f, 1'b0);
        for (int i = 0; i < 16; i++) begin
            run((i < 4) ? 2'(i) : 2'($random(seed)), 6'($random(seed)), i == 1);
        end
        @(posedge sys_clk);
        #2;
        rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        #2;
        rst = 1'b0;
        sr = 6'h3f;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(atten_code_q, SAC_RESET_CODE);
        run(SAC_DIRECT_SERIAL, 6'h2a, 1'b0);
        wrap_up();
    end
endmodule
